// ==== dv/spi_register_access_lock_bench.sv ====
// Bench joining host and device ends over the serial link.
// Assumes default half period and frame gap of the host end.
`timescale 1ns/1ps
`default_nettype none
module spi_register_access_lock_bench;
  logic clk;
  logic rst_n;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_addr;
  logic [15:0] cmd_data;
  logic cmd_long;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [15:0] conv_data;
  logic map_open;
  logic readback_mode;
  logic [2:0] lane_count;
  logic [15:0] r;
  logic lng;
  logic [3:0] oe_seen;
  int mismatches;
  int n_checks;
  spi_link_if link ();
  reg_access_host i_reg_access_host (.clk(clk), .rst_n(rst_n),
    .link(link.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_long(cmd_long),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  reg_access_device i_reg_access_device (.clk(clk), .rst_n(rst_n),
    .link(link.device), .conv_data(conv_data), .map_open(map_open),
    .readback_mode(readback_mode), .lane_count(lane_count));
  spi_register_access_lock_props i_spi_register_access_lock_props (
    .clk(clk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
    .sdi(link.sdi), .lane_oe_n(link.lane_oe_n));
  always #5 clk = ~clk;
  // Keeps the lane enables last seen inside a frame.
  always @(negedge clk)
  begin
    if (!link.cs_n)
      oe_seen <= link.lane_oe_n;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One frame through the host; r takes what lane three carried.
  task automatic xfer(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cmd_addr <= a;
    cmd_data <= d;
    cmd_long <= lng;
    cmd_valid <= 1'b1;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 1000);
    chk({15'h0000, rsp_valid}, 16'h0001);
    r = rsp_data;
    repeat (8) @(negedge clk);
  endtask
  task automatic unlock;
    xfer(8'hFE, spi_lock_pkg::KEY_FIRST);
    xfer(8'hFE, spi_lock_pkg::KEY_SECOND);
  endtask
  // Readback request, then a frame that turns readback off again.
  task automatic rd(input logic [7:0] a);
    xfer(8'h01, {a, 8'h01});
    chk({15'h0000, readback_mode}, 16'h0001);
    xfer(8'h01, 16'h0000);
    chk({12'h000, oe_seen}, 16'h0007);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_addr = 8'h00;
    cmd_data = 16'h0000;
    cmd_long = 1'b0;
    lng = 1'b0;
    conv_data = 16'h5A3C;
    mismatches = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({15'h0000, map_open}, 16'h0000);
    xfer(8'h02, 16'h0002);
    chk({12'h000, oe_seen}, 16'h0000);
    xfer(8'hFE, spi_lock_pkg::KEY_FIRST);
    xfer(8'hFE, 16'h5555);
    chk({15'h0000, map_open}, 16'h0000);
    unlock;
    chk({15'h0000, map_open}, 16'h0001);
    rd(8'h02);
    chk(r, 16'h0000);
    xfer(8'h02, 16'h0002);
    xfer(8'h0C, 16'h0200);
    xfer(8'h03, 16'h000B);
    xfer(8'h02, 16'h0008);
    xfer(8'h22, 16'h0080);
    rd(8'h22);
    chk(r, 16'h0080);
    rd(8'h03);
    chk(r, 16'h000B);
    xfer(8'h03, 16'h0000);
    xfer(8'h22, 16'h1111);
    xfer(8'h03, 16'h000B);
    rd(8'h22);
    chk(r, 16'h0080);
    xfer(8'h02, 16'h0000);
    xfer(8'h0C, 16'hFFFF);
    xfer(8'h02, 16'h0002);
    rd(8'h0C);
    chk(r, 16'h0200);
    xfer(8'h09, 16'h0050);
    chk({13'h0000, lane_count}, 16'h0005);
    xfer(8'h10, 16'hA5C3);
    chk(r, conv_data);
    chk({12'h000, oe_seen}, 16'h0005);
    xfer(8'h09, 16'h0060);
    chk({13'h0000, lane_count}, 16'h0006);
    lng = 1'b1;
    rd(8'h10);
    chk(r, 16'hA5C3);
    xfer(8'h09, 16'h0000);
    chk({13'h0000, lane_count}, 16'h0000);
    lng = 1'b0;
    xfer(8'hFE, spi_lock_pkg::KEY_RELOCK);
    chk({15'h0000, map_open}, 16'h0000);
    xfer(8'h10, 16'h0000);
    unlock;
    rd(8'h10);
    chk(r, 16'hA5C3);
    xfer(8'h01, 16'h0002);
    chk({15'h0000, map_open}, 16'h0000);
    unlock;
    rd(8'h03);
    chk(r, 16'h0000);
    rd(8'h02);
    chk(r, 16'h0000);
    complete_run;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    complete_run;
  end
endmodule
`default_nettype wire

// ==== dv/spi_register_access_lock_props.sv ====
// Checker for the serial link between the host end and the device end.
// Assumes it is instantiated beside the link interface at default timing.
`timescale 1ns/1ps
`default_nettype none
module spi_register_access_lock_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic [3:0] lane_oe_n
);
  logic [5:0] rises_q;
  logic sclk_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Link clock edges counted within a frame
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rises_q <= 6'h00;
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_n)
        rises_q <= 6'h00;
      else if (sclk && !sclk_q)
        rises_q <= rises_q + 6'h01;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("link clock high outside a frame");
  a_sdi_stable_rise: assert property ($rose(sclk) |-> $stable(sdi))
    else $error("serial input moved at a rising link clock");
  a_clock_high_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase has the wrong length");
  a_frame_lead_in: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
    else $error("first link clock rise at the wrong time");
  a_frame_clock_count: assert property ($rose(cs_n) |->
    rises_q == 6'h18 || rises_q == 6'h30)
    else $error("frame holds neither 24 nor 48 link clocks");
  a_frame_gap_hold: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("next frame started too soon");
  a_lanes_off_idle: assert property (cs_n [*6] |-> lane_oe_n == 4'hF)
    else $error("data lane enabled between frames");
  a_lane_enable_set: assert property (lane_oe_n == 4'hF || lane_oe_n == 4'h7
    || lane_oe_n == 4'h5 || lane_oe_n == 4'h0)
    else $error("data lane enables outside the lane count codes");
endmodule
`default_nettype wire

// ==== logic/reg_access_device.sv ====
// Device end: locked register map reached over the serial link.
// Assumes sclk only toggles while cs_n is low, and that the host leaves
// several clk cycles between frames so the decode settles first.
`timescale 1ns/1ps
`default_nettype none
module reg_access_device (
  input wire logic clk,
  input wire logic rst_n,
  spi_link_if.device link,
  input wire logic [15:0] conv_data,
  output logic map_open,
  output logic readback_mode,
  output logic [2:0] lane_count
);
  // ****************************************************************
  // Register state and link state.
  // ****************************************************************
  typedef struct packed {
    spi_lock_pkg::lock_t lock;
    logic open;
    logic cs_prev;
    logic armed;
    logic tog;
    logic [15:0] r_readback;
    logic [15:0] r_bank_sel;
    logic [15:0] r_bank2_key;
    logic [15:0] r_map_key;
    logic [15:0] r_bank2_init;
    logic [spi_lock_pkg::BANK1_REGS-1:0][15:0] bank1;
    logic [15:0] rb_word;
    logic [3:0] oe_n;
  } core_t;
  typedef struct packed {
    logic [47:0] sr;
    logic [5:0] cnt;
    logic seen;
    logic [3:0] lane;
  } link_t;
  core_t q;
  core_t d;
  link_t lq;
  link_t ld;
  logic cs_sync;

  // ****************************************************************
  // Decode helpers.
  // ****************************************************************
  // Maps a bank one address to its storage slot, NO_SLOT if unlisted.
  function automatic logic [3:0] slot_of(input logic [7:0] a);
    logic [3:0] s;
    s = spi_lock_pkg::NO_SLOT;
    case (a)
      spi_lock_pkg::ADDR_PDN: s = 4'h0;
      spi_lock_pkg::ADDR_LANE_CFG: s = 4'h1;
      spi_lock_pkg::ADDR_DRIVE: s = 4'h2;
      spi_lock_pkg::ADDR_DELAY: s = 4'h3;
      spi_lock_pkg::ADDR_REFCLK: s = 4'h4;
      spi_lock_pkg::ADDR_FRAME_PROC: s = 4'h5;
      spi_lock_pkg::ADDR_PATT_CTL: s = 4'h6;
      spi_lock_pkg::ADDR_PATT_ONE: s = 4'h7;
      spi_lock_pkg::ADDR_PATT_TWO: s = 4'h8;
      spi_lock_pkg::ADDR_SHORT_MODE: s = 4'h9;
      default: s = spi_lock_pkg::NO_SLOT;
    endcase
    return s;
  endfunction

  function automatic logic bank2_open(input core_t c);
    return c.r_bank_sel[3:0] == spi_lock_pkg::BANK_TWO &&
      c.r_bank2_key[3:0] == spi_lock_pkg::BANK2_UNLOCK;
  endfunction

  // Reads one register as the active bank sees it; unmapped reads zero.
  function automatic logic [15:0] read_reg(input core_t c,
    input logic [7:0] a);
    logic [15:0] v;
    logic [3:0] s;
    v = 16'h0000;
    s = slot_of(a);
    case (a)
      spi_lock_pkg::ADDR_READBACK: v = c.r_readback;
      spi_lock_pkg::ADDR_BANK_SEL: v = c.r_bank_sel;
      spi_lock_pkg::ADDR_BANK2_KEY: v = c.r_bank2_key;
      spi_lock_pkg::ADDR_MAP_KEY: v = c.r_map_key;
      spi_lock_pkg::ADDR_BANK2_INIT:
        v = bank2_open(c) ? c.r_bank2_init : 16'h0000;
      default:
        if (s != spi_lock_pkg::NO_SLOT &&
            c.r_bank_sel[3:0] == spi_lock_pkg::BANK_ONE)
          v = c.bank1[s];
    endcase
    return v;
  endfunction

  function automatic core_t reset_core(input logic tog);
    core_t c;
    c = '0;
    c.lock = spi_lock_pkg::LK_LOCKED;
    c.r_readback = spi_lock_pkg::REG_RESET;
    c.r_bank_sel = spi_lock_pkg::REG_RESET;
    c.r_bank2_key = spi_lock_pkg::REG_RESET;
    c.r_map_key = spi_lock_pkg::REG_RESET;
    c.r_bank2_init = spi_lock_pkg::REG_RESET;
    c.cs_prev = 1'b1;
    c.oe_n = 4'hF;
    c.tog = tog;
    return c;
  endfunction

  sync_two_ff #(.W(1)) u_cs_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.cs_n),
    .q(cs_sync)
  );

  // ****************************************************************
  // Frame decode in the clk domain.
  // ****************************************************************
  // The shift register is read only after cs_n has risen and sclk has
  // stopped, so it is stable when this domain samples it.
  always_comb
  begin
    logic [23:0] frame;
    logic [7:0] addr;
    logic [15:0] data;
    logic [3:0] s;
    logic [2:0] lanes;
    frame = 24'h000000;
    addr = 8'h00;
    data = 16'h0000;
    s = spi_lock_pkg::NO_SLOT;
    lanes = 3'h0;
    d = q;
    d.cs_prev = cs_sync;
    // The synchroniser leaves reset low, so its first rise ends no frame.
    d.armed = q.armed | cs_sync;
    if (cs_sync && !q.cs_prev && q.armed)
    begin
      d.tog = ~q.tog;
      if (lq.cnt == spi_lock_pkg::FRAME_LONG)
        frame = lq.sr[47:24];
      else
        frame = lq.sr[23:0];
      addr = frame[23:16];
      data = frame[15:0];
      s = slot_of(addr);
      if (addr == spi_lock_pkg::ADDR_MAP_KEY)
      begin
        d.r_map_key = data;
        if (data == spi_lock_pkg::KEY_FIRST)
          d.lock = spi_lock_pkg::LK_KEY1;
        else if (data == spi_lock_pkg::KEY_SECOND &&
                 q.lock == spi_lock_pkg::LK_KEY1)
          d.lock = spi_lock_pkg::LK_OPEN;
        else
          d.lock = spi_lock_pkg::LK_LOCKED;
      end
      else if (q.lock != spi_lock_pkg::LK_OPEN)
        d.lock = spi_lock_pkg::LK_LOCKED;
      else
        case (addr)
          spi_lock_pkg::ADDR_READBACK:
            if (data[spi_lock_pkg::RESET_BIT])
              d = reset_core(~q.tog);
            else
            begin
              d.r_readback = data;
              if (data[spi_lock_pkg::DATA_SEL_BIT])
                d.rb_word = read_reg(q,
                  data[spi_lock_pkg::RD_ADDR_LSB +: 8]);
            end
          spi_lock_pkg::ADDR_BANK_SEL: d.r_bank_sel = data;
          spi_lock_pkg::ADDR_BANK2_KEY: d.r_bank2_key = data;
          spi_lock_pkg::ADDR_BANK2_INIT:
            if (bank2_open(q))
              d.r_bank2_init = data;
          default:
            if (s != spi_lock_pkg::NO_SLOT &&
                q.r_bank_sel[3:0] == spi_lock_pkg::BANK_ONE)
              d.bank1[s] = data;
        endcase
    end
    d.open = d.lock == spi_lock_pkg::LK_OPEN;
    lanes = d.bank1[1][spi_lock_pkg::LANES_LSB +: 3];
    if (cs_sync)
      d.oe_n = 4'hF;
    else if (d.r_readback[spi_lock_pkg::DATA_SEL_BIT])
      d.oe_n = 4'h7;
    else
      case (lanes)
        spi_lock_pkg::LANES_FOUR: d.oe_n = 4'h0;
        spi_lock_pkg::LANES_TWO: d.oe_n = 4'h5;
        spi_lock_pkg::LANES_ONE: d.oe_n = 4'h7;
        default: d.oe_n = 4'hF;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= reset_core(1'b0);
    else
      q <= d;
  end

  // ****************************************************************
  // Shift and launch in the sclk domain.
  // ****************************************************************
  // A changed frame token from the clk domain marks the first edge of a
  // new frame, since sclk gives no edge to clear the count on.
  always_comb
  begin
    logic [5:0] c;
    logic [15:0] word;
    c = (q.tog != lq.seen) ? 6'h00 : lq.cnt;
    word = q.r_readback[spi_lock_pkg::DATA_SEL_BIT] ? q.rb_word
      : conv_data;
    ld = lq;
    ld.seen = q.tog;
    ld.sr = {lq.sr[46:0], link.sdi};
    ld.cnt = (c == 6'h3F) ? c : c + 6'h01;
    ld.lane = 4'h0;
    if (c < spi_lock_pkg::READ_BITS)
      ld.lane[3] = word[4'hF - c[3:0]];
  end

  always_ff @(posedge link.sclk or negedge rst_n)
  begin
    if (!rst_n)
      lq <= '0;
    else
      lq <= ld;
  end

  assign link.lane_out = lq.lane;
  assign link.lane_oe_n = q.oe_n;
  assign map_open = q.open;
  assign readback_mode = q.r_readback[spi_lock_pkg::DATA_SEL_BIT];
  assign lane_count = q.bank1[1][spi_lock_pkg::LANES_LSB +: 3];
endmodule
`default_nettype wire

// ==== logic/reg_access_host.sv ====
// Host end: turns one register command into one serial frame.
// Assumes the command source orders key, bank and relock frames itself.
`timescale 1ns/1ps
`default_nettype none
module reg_access_host #(
  parameter int HALF_CYC = spi_lock_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC = spi_lock_pkg::FRAME_GAP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  spi_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic cmd_long,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_HOLD, H_GAP}
    hstate_t;
  typedef struct packed {
    hstate_t st;
    logic [7:0] tmr;
    logic [47:0] sh;
    logic [5:0] nbits;
    logic [5:0] bit_n;
    logic [15:0] rx;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic ready;
    logic rsp_v;
  } host_t;
  host_t q;
  host_t d;
  logic lane3;

  sync_two_ff #(.W(1)) u_lane_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.lane_out[3]),
    .q(lane3)
  );

  // ****************************************************************
  // Frame sequencer.
  // ****************************************************************
  // The source must unlock with the key pair, key bank two, follow the
  // start-up write order, avoid unlisted addresses and relock at the end.
  always_comb
  begin
    d = q;
    d.rsp_v = 1'b0;
    d.tmr = (q.tmr == 8'h00) ? q.tmr : q.tmr - 8'h01;
    case (q.st)
      H_IDLE:
        if (cmd_valid)
        begin
          d.sh = {cmd_addr, cmd_data, 24'h000000};
          d.nbits = cmd_long ? spi_lock_pkg::FRAME_LONG
            : spi_lock_pkg::FRAME_SHORT;
          d.bit_n = 6'h00;
          d.cs_n = 1'b0;
          d.sdi = cmd_addr[7];
          d.ready = 1'b0;
          d.tmr = 8'(HALF_CYC - 1);
          d.st = H_LOW;
        end
      H_LOW:
        if (q.tmr == 8'h00)
        begin
          d.sclk = 1'b1;
          d.tmr = 8'(HALF_CYC - 1);
          d.st = H_HIGH;
        end
      H_HIGH:
        if (q.tmr == 8'h00)
        begin
          if (q.bit_n < spi_lock_pkg::READ_BITS)
            d.rx = {q.rx[14:0], lane3};
          d.sclk = 1'b0;
          d.bit_n = q.bit_n + 6'h01;
          d.sh = {q.sh[46:0], 1'b0};
          d.sdi = q.sh[46];
          d.tmr = 8'(HALF_CYC - 1);
          d.st = (q.bit_n == q.nbits - 6'h01) ? H_HOLD : H_LOW;
        end
      H_HOLD:
        if (q.tmr == 8'h00)
        begin
          d.cs_n = 1'b1;
          d.sdi = 1'b0;
          d.rsp_v = 1'b1;
          d.tmr = 8'(GAP_CYC - 1);
          d.st = H_GAP;
        end
      H_GAP:
        if (q.tmr == 8'h00)
        begin
          d.ready = 1'b1;
          d.st = H_IDLE;
        end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= H_IDLE;
      q.cs_n <= 1'b1;
      q.ready <= 1'b1;
    end
    else
      q <= d;
  end

  assign link.cs_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.sdi = q.sdi;
  assign cmd_ready = q.ready;
  assign rsp_valid = q.rsp_v;
  assign rsp_data = q.rx;
endmodule
`default_nettype wire

// ==== logic/spi_link_if.sv ====
// Serial link between the host end and the register device end.
// Assumes the bench resolves each data lane from its active-low enable.
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic [3:0] lane_out;
  logic [3:0] lane_oe_n;
  modport host (output cs_n, output sclk, output sdi,
    input lane_out, input lane_oe_n);
  modport device (input cs_n, input sclk, input sdi,
    output lane_out, output lane_oe_n);
endinterface
`default_nettype wire

// ==== logic/spi_lock_pkg.sv ====
// Constants and types shared by both ends of the register access link.
// Assumes a 16-bit register map reached by 24- or 48-clock serial frames.
package spi_lock_pkg;
  localparam logic [7:0] ADDR_READBACK = 8'h01;
  localparam logic [7:0] ADDR_BANK_SEL = 8'h02;
  localparam logic [7:0] ADDR_BANK2_KEY = 8'h03;
  localparam logic [7:0] ADDR_MAP_KEY = 8'hFE;
  localparam logic [7:0] ADDR_PDN = 8'h08;
  localparam logic [7:0] ADDR_LANE_CFG = 8'h09;
  localparam logic [7:0] ADDR_DRIVE = 8'h0A;
  localparam logic [7:0] ADDR_DELAY = 8'h0B;
  localparam logic [7:0] ADDR_REFCLK = 8'h0C;
  localparam logic [7:0] ADDR_FRAME_PROC = 8'h0D;
  localparam logic [7:0] ADDR_PATT_CTL = 8'h0F;
  localparam logic [7:0] ADDR_PATT_ONE = 8'h10;
  localparam logic [7:0] ADDR_PATT_TWO = 8'h11;
  localparam logic [7:0] ADDR_SHORT_MODE = 8'h13;
  localparam logic [7:0] ADDR_BANK2_INIT = 8'h22;
  localparam logic [15:0] KEY_FIRST = 16'hB38F;
  localparam logic [15:0] KEY_SECOND = 16'hABCD;
  localparam logic [15:0] KEY_RELOCK = 16'h1234;
  localparam logic [3:0] BANK_ZERO = 4'h0;
  localparam logic [3:0] BANK_ONE = 4'h2;
  localparam logic [3:0] BANK_TWO = 4'h8;
  localparam logic [3:0] BANK2_UNLOCK = 4'hB;
  localparam logic [2:0] LANES_FOUR = 3'h0;
  localparam logic [2:0] LANES_TWO = 3'h5;
  localparam logic [2:0] LANES_ONE = 3'h6;
  localparam int LANES_LSB = 4;
  localparam int RD_ADDR_LSB = 8;
  localparam int RESET_BIT = 1;
  localparam int DATA_SEL_BIT = 0;
  localparam logic [5:0] FRAME_SHORT = 6'h18;
  localparam logic [5:0] FRAME_LONG = 6'h30;
  localparam logic [5:0] READ_BITS = 6'h10;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int BANK1_REGS = 10;
  localparam logic [3:0] NO_SLOT = 4'hF;
  localparam int SCLK_HALF_CYC = 4;
  localparam int FRAME_GAP_CYC = 8;
  typedef enum logic [1:0] {LK_LOCKED, LK_KEY1, LK_OPEN} lock_t;
endpackage

// ==== logic/sync_two_ff.sv ====
// Two-flop level synchroniser.
// Assumes the input is a level from another clock domain or a pin.
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t st_q;
  sync_t st_d;
  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign q = st_q.s2;
endmodule
`default_nettype wire
